// >>> rtl/dps_defs.svh
// Timing, geometry and flag-bit constants for the semaphore port host
`ifndef DPS_DEFS_SVH
`define DPS_DEFS_SVH

`define DPS_PERIOD_NS      40
`define DPS_SEM_COUNT      8
`define DPS_SEL_W          3
`define DPS_DATA_W         8
`define DPS_ADDR_W         12
`define DPS_SYNC_STAGES    2
`define DPS_FLAG_UPDATE_GAP_NS     10
`define DPS_WRITE_TO_READ_DELAY_NS 5
`define DPS_ENABLE_TO_DATA_DELAY_NS 25
`define DPS_WRITE_PULSE_NS 50
`define DPS_CYC(ns) ((((ns) + `DPS_PERIOD_NS - 1) / `DPS_PERIOD_NS) < 1 ? \
   1 : (((ns) + `DPS_PERIOD_NS - 1) / `DPS_PERIOD_NS))
`define DPS_GAP_CYC    `DPS_CYC(`DPS_FLAG_UPDATE_GAP_NS)
`define DPS_WPULSE_CYC `DPS_CYC(`DPS_WRITE_PULSE_NS)
`define DPS_READ_CYC   (`DPS_CYC(`DPS_WRITE_TO_READ_DELAY_NS + \
   `DPS_ENABLE_TO_DATA_DELAY_NS) + `DPS_SYNC_STAGES + 1)
`define DPS_REQUEST_BIT    1'h0
`define DPS_FREE_BIT       1'h1

`endif

// >>> rtl/dps_pkg.sv
// Types shared by the semaphore port host
package dps_pkg;

   typedef enum logic [1:0] {
      DPS_OP_INIT    = 2'h0,
      DPS_OP_ACQUIRE = 2'h1,
      DPS_OP_TRY     = 2'h2,
      DPS_OP_RELEASE = 2'h3
   } dps_op_t;

   typedef enum logic [7:0] {
      DPS_S_BOOT   = 8'h01,
      DPS_S_IDLE   = 8'h02,
      DPS_S_WSET   = 8'h04,
      DPS_S_WPULSE = 8'h08,
      DPS_S_WEND   = 8'h10,
      DPS_S_GAP    = 8'h20,
      DPS_S_READ   = 8'h40,
      DPS_S_RESP   = 8'h80
   } dps_state_t;

endpackage

// >>> rtl/dps_sem_host.sv
// Host that drives one port of a dual-port semaphore device
`timescale 1ns/1ps
`default_nettype none
`include "dps_defs.svh"

module dps_sem_host
   import dps_pkg::*;
#(
   parameter int SEM_COUNT = `DPS_SEM_COUNT,
   parameter int SEL_W     = `DPS_SEL_W,
   parameter int DATA_W    = `DPS_DATA_W,
   parameter int ADDR_W    = `DPS_ADDR_W
) (
   input  wire logic              clk,
   input  wire logic              resetn,
   input  wire logic              cmd_valid,
   output var  logic              cmd_ready,
   input  wire dps_op_t           cmd_op,
   input  wire logic [SEL_W-1:0]  cmd_sel,
   input  wire logic              acquire_cancel,
   output var  logic              rsp_valid,
   output var  logic              rsp_granted,
   output var  logic [ADDR_W-1:0] sem_addr,
   output var  logic              mem_select_n,
   output var  logic              semaphore_select_n,
   output var  logic              rw_n,
   output var  logic              oe_n,
   output var  logic [DATA_W-1:0] sem_data_out,
   output var  logic              sem_data_oe_n,
   input  wire logic [DATA_W-1:0] sem_data_in
);

   localparam logic [3:0] GAP_LAST    = 4'(`DPS_GAP_CYC - 1);
   localparam logic [3:0] WPULSE_LAST = 4'(`DPS_WPULSE_CYC - 1);
   localparam logic [3:0] READ_LAST   = 4'(`DPS_READ_CYC - 1);
   localparam logic [SEL_W-1:0] SEL_LAST = SEL_W'(SEM_COUNT - 1);

   dps_state_t        state_reg, state_next;
   dps_op_t           op_reg, op_next;
   logic [SEL_W-1:0]  sel_reg, sel_next;
   logic [3:0]        cnt_reg, cnt_next;
   logic              wbit_reg, wbit_next;
   logic              grant_reg, grant_next;
   logic              rsp_valid_reg, rsp_valid_next;
   logic              boot_reg, boot_next;
   logic              sem_n_reg, sem_n_next;
   logic              rw_n_reg, rw_n_next;
   logic              oe_n_reg, oe_n_next;
   logic              drv_n_reg, drv_n_next;
   logic [DATA_W-1:0] dout_reg, dout_next;
   logic [ADDR_W-1:0] addr_reg, addr_next;
   logic [DATA_W-1:0] din_sync;

   dps_sync #(
      .W (DATA_W)
   ) u_din_sync (
      .clk    (clk),
      .resetn (resetn),
      .d      (sem_data_in),
      .q      (din_sync)
   );

   // Sequencer
   always_comb begin
      state_next     = state_reg;
      op_next        = op_reg;
      sel_next       = sel_reg;
      cnt_next       = cnt_reg;
      wbit_next      = wbit_reg;
      grant_next     = grant_reg;
      rsp_valid_next = 1'b0;
      boot_next      = boot_reg;
      case (state_reg)
         DPS_S_BOOT: begin
            op_next    = DPS_OP_INIT;
            sel_next   = '0;
            wbit_next  = `DPS_FREE_BIT;
            state_next = DPS_S_WSET;
         end
         DPS_S_IDLE: begin
            if (cmd_valid) begin
               op_next    = cmd_op;
               sel_next   = (cmd_op == DPS_OP_INIT) ? '0 : cmd_sel;
               grant_next = 1'b0;
               wbit_next  = (cmd_op == DPS_OP_ACQUIRE ||
                             cmd_op == DPS_OP_TRY) ?
                            `DPS_REQUEST_BIT : `DPS_FREE_BIT;
               state_next = DPS_S_WSET;
            end
         end
         DPS_S_WSET: begin
            cnt_next   = '0;
            state_next = DPS_S_WPULSE;
         end
         DPS_S_WPULSE: begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == WPULSE_LAST) begin
               state_next = DPS_S_WEND;
            end
         end
         DPS_S_WEND: begin
            cnt_next   = '0;
            state_next = DPS_S_GAP;
         end
         DPS_S_GAP: begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == GAP_LAST) begin
               cnt_next = '0;
               if (wbit_reg == `DPS_REQUEST_BIT) begin
                  state_next = DPS_S_READ;
               end else if (op_reg == DPS_OP_INIT && sel_reg != SEL_LAST) begin
                  sel_next   = sel_reg + 1'b1;
                  state_next = DPS_S_WSET;
               end else begin
                  state_next = DPS_S_RESP;
               end
            end
         end
         DPS_S_READ: begin
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == READ_LAST) begin
               cnt_next = '0;
               if (din_sync[0] == `DPS_REQUEST_BIT) begin
                  grant_next = 1'b1;
                  state_next = DPS_S_RESP;
               end else if (op_reg == DPS_OP_ACQUIRE && !acquire_cancel) begin
                  state_next = DPS_S_GAP;
               end else begin
                  wbit_next  = `DPS_FREE_BIT;
                  state_next = DPS_S_WSET;
               end
            end
         end
         DPS_S_RESP: begin
            // Boot init answers nobody
            rsp_valid_next = !boot_reg;
            boot_next      = 1'b0;
            state_next     = DPS_S_IDLE;
         end
         default: begin
            state_next = DPS_S_BOOT;
         end
      endcase
   end

   // Pin levels follow the next state
   always_comb begin
      sem_n_next = 1'b1;
      rw_n_next  = 1'b1;
      oe_n_next  = 1'b1;
      drv_n_next = 1'b1;
      dout_next  = dout_reg;
      addr_next  = ADDR_W'(sel_next);
      case (state_next)
         DPS_S_WSET: begin
            sem_n_next = 1'b0;
            drv_n_next = 1'b0;
            dout_next  = DATA_W'(wbit_next);
         end
         DPS_S_WPULSE: begin
            sem_n_next = 1'b0;
            rw_n_next  = 1'b0;
            drv_n_next = 1'b0;
         end
         DPS_S_WEND: begin
            sem_n_next = 1'b0;
            drv_n_next = 1'b0;
         end
         DPS_S_READ: begin
            sem_n_next = 1'b0;
            oe_n_next  = 1'b0;
         end
         default: begin
            sem_n_next = 1'b1;
         end
      endcase
   end

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_reg     <= DPS_S_BOOT;
         op_reg        <= DPS_OP_INIT;
         sel_reg       <= '0;
         cnt_reg       <= '0;
         wbit_reg      <= `DPS_FREE_BIT;
         grant_reg     <= 1'b0;
         rsp_valid_reg <= 1'b0;
         boot_reg      <= 1'b1;
         sem_n_reg     <= 1'b1;
         rw_n_reg      <= 1'b1;
         oe_n_reg      <= 1'b1;
         drv_n_reg     <= 1'b1;
         dout_reg      <= '0;
         addr_reg      <= '0;
      end else begin
         state_reg     <= state_next;
         op_reg        <= op_next;
         sel_reg       <= sel_next;
         cnt_reg       <= cnt_next;
         wbit_reg      <= wbit_next;
         grant_reg     <= grant_next;
         rsp_valid_reg <= rsp_valid_next;
         boot_reg      <= boot_next;
         sem_n_reg     <= sem_n_next;
         rw_n_reg      <= rw_n_next;
         oe_n_reg      <= oe_n_next;
         drv_n_reg     <= drv_n_next;
         dout_reg      <= dout_next;
         addr_reg      <= addr_next;
      end
   end

   assign cmd_ready          = (state_reg == DPS_S_IDLE);
   assign rsp_valid          = rsp_valid_reg;
   assign rsp_granted        = grant_reg;
   assign sem_addr           = addr_reg;
   assign mem_select_n       = 1'b1;
   assign semaphore_select_n = sem_n_reg;
   assign rw_n               = rw_n_reg;
   assign oe_n               = oe_n_reg;
   assign sem_data_out       = dout_reg;
   assign sem_data_oe_n      = drv_n_reg;

endmodule // dps_sem_host

`default_nettype wire

// >>> rtl/dps_sync.sv
// Two-stage synchroniser for pin inputs
`timescale 1ns/1ps
`default_nettype none

module dps_sync #(
   parameter int W = 8
) (
   input  wire logic         clk,
   input  wire logic         resetn,
   input  wire logic [W-1:0] d,
   output var  logic [W-1:0] q
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] q_reg;

   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         meta_reg <= '0;
         q_reg    <= '0;
      end else begin
         meta_reg <= d;
         q_reg    <= meta_reg;
      end
   end

   assign q = q_reg;

endmodule // dps_sync

`default_nettype wire

// >>> test/dps_dev_model.sv
// Behavioural two-port semaphore device
`timescale 1ns/1ps
`default_nettype none
module dps_dev_model (
   input  wire logic        semaphore_select_n,
   input  wire logic        rw_n,
   input  wire logic        oe_n,
   input  wire logic [11:0] sem_addr,
   input  wire logic [7:0]  lbus,
   output var  logic [7:0]  sem_data_in,
   input  wire logic        r_sem_n,
   input  wire logic        r_rw_n,
   input  wire logic [2:0]  r_sel,
   input  wire logic        r_d0,
   output var  logic        r_q
);
   // Owner 0 free, 1 left, 2 right; power-up owner left for all eight
   logic [1:0] own [8] = '{default: 2'h1};
   logic [1:0] pend [8] = '{default: 2'h0};
   logic [7:0] held = 8'h00;
   wire wl = !semaphore_select_n && !rw_n;
   wire wr = !r_sem_n && !r_rw_n;
   wire rd = !semaphore_select_n && !oe_n && rw_n;
   task automatic wrt(input logic [1:0] p, input logic [2:0] s,
         input logic v);
      if (!v) begin
         if (own[s] == 2'h0) own[s] = p;
         else if (own[s] != p) pend[s][p-2'h1] = 1'b1;
      end else if (own[s] == p) begin
         own[s] = pend[s][2'h2-p] ? 2'h3 - p : 2'h0;
         pend[s] = 2'h0;
      end else pend[s][p-2'h1] = 1'b0;
   endtask
   // Writes land one at a time, so a tie has one winner
   always @(negedge wl) if ($time > 0)
      wrt(2'h1, sem_addr[2:0], lbus[0]);
   always @(negedge wr) if ($time > 0) wrt(2'h2, r_sel, r_d0);
   always @(posedge rd) held = {8{own[sem_addr[2:0]] != 2'h1}};
   assign sem_data_in = rd ? held : ~held;
   assign r_q = own[r_sel] != 2'h2;
endmodule // dps_dev_model
`default_nettype wire

// >>> test/dps_sem_host_asserts.sv
// Port timing checks for the semaphore port host
`timescale 1ns/1ps
`default_nettype none
module dps_sem_host_asserts #(
   parameter int DATA_W = 8,
   parameter int ADDR_W = 12
) (
   input wire logic              clk,
   input wire logic              resetn,
   input wire logic              rsp_valid,
   input wire logic              cmd_ready,
   input wire logic [ADDR_W-1:0] sem_addr,
   input wire logic              mem_select_n,
   input wire logic              semaphore_select_n,
   input wire logic              rw_n,
   input wire logic              oe_n,
   input wire logic [DATA_W-1:0] sem_data_out,
   input wire logic              sem_data_oe_n
);
   default clocking @(posedge clk); endclocking
   default disable iff (!resetn);
   chk_mem_sel_off: assert property (
      !semaphore_select_n |-> mem_select_n) else $error("mem select low");
   chk_write_select: assert property (
      !rw_n |-> !semaphore_select_n && oe_n && !sem_data_oe_n)
      else $error("bad write cycle");
   chk_write_pulse: assert property (
      $fell(rw_n) |-> !rw_n ##1 !rw_n ##1 rw_n && !semaphore_select_n)
      else $error("bad write pulse");
   chk_flag_gap: assert property (
      $rose(rw_n) |=> semaphore_select_n && sem_data_oe_n)
      else $error("no gap after write");
   chk_read_window: assert property (
      $fell(oe_n) |-> (!oe_n && !semaphore_select_n && rw_n) [*4] ##1 oe_n)
      else $error("bad read window");
   chk_write_data: assert property (
      !sem_data_oe_n |-> sem_data_out inside {8'h00, 8'h01})
      else $error("bad write data");
   chk_addr_low: assert property (
      !semaphore_select_n |-> sem_addr[ADDR_W-1:3] == '0)
      else $error("high address bits set");
   chk_rsp_pulse: assert property (
      rsp_valid |-> cmd_ready ##1 !rsp_valid) else $error("bad response");
endmodule // dps_sem_host_asserts
bind dps_sem_host dps_sem_host_asserts #(.DATA_W(DATA_W), .ADDR_W(ADDR_W))
   u_dps_sem_host_asserts (.clk, .resetn, .rsp_valid, .cmd_ready,
   .sem_addr, .mem_select_n, .semaphore_select_n, .rw_n, .oe_n,
   .sem_data_out, .sem_data_oe_n);
`default_nettype wire

// >>> test/dps_sem_host_bench.sv
// Self-checking bench for the semaphore port host
`timescale 1ns/1ps
`default_nettype none
module dps_sem_host_bench;
   import dps_pkg::*;
   logic        clk, resetn, cmd_valid, acquire_cancel, g;
   logic        cmd_ready, rsp_valid, rsp_granted, mem_select_n;
   logic        semaphore_select_n, rw_n, oe_n, sem_data_oe_n;
   logic        r_sem_n, r_rw_n, r_d0, r_q;
   dps_op_t     cmd_op;
   logic [2:0]  cmd_sel, r_sel;
   logic [11:0] sem_addr;
   logic [7:0]  sem_data_out, sem_data_in, lbus;
   int          err_count, n_checks;
   // Released data lines show the inverse of the last drive
   assign lbus = sem_data_oe_n ? ~sem_data_out : sem_data_out;
   dps_sem_host u_dps_sem_host (.clk, .resetn, .cmd_valid, .cmd_ready,
      .cmd_op, .cmd_sel, .acquire_cancel, .rsp_valid, .rsp_granted,
      .sem_addr, .mem_select_n, .semaphore_select_n, .rw_n, .oe_n,
      .sem_data_out, .sem_data_oe_n, .sem_data_in);
   dps_dev_model u_dps_dev_model (.semaphore_select_n, .rw_n, .oe_n,
      .sem_addr, .lbus, .sem_data_in, .r_sem_n, .r_rw_n, .r_sel, .r_d0,
      .r_q);
   task automatic tick;
      @(posedge clk);
      #1;
   endtask
   task automatic chk(input logic seen, input logic exp);
      n_checks++;
      if (seen !== exp) begin
         err_count++;
         $display("wrong value at %0t: %b not %b", $time, seen, exp);
      end
   endtask
   task automatic print_verdict;
      if (err_count == 0 && n_checks > 0) $display("Result: passed");
      else $display("Result: failed");
      $finish;
   endtask
   task automatic cmd(input dps_op_t op, input logic [2:0] s);
      int i;
      bit to;
      for (i = 0; i < 3000 && cmd_ready !== 1'b1; i++) tick;
      to = (i == 3000);
      cmd_op = op;
      cmd_sel = s;
      cmd_valid = 1'b1;
      tick;
      cmd_valid = 1'b0;
      for (i = 0; i < 3000 && rsp_valid !== 1'b1; i++) tick;
      if (to || i == 3000) begin
         err_count++;
         print_verdict;
      end else begin
         g = rsp_granted;
      end
   endtask
   // Far-port write of one semaphore
   task automatic rw(input logic [2:0] s, input logic v);
      r_sel = s;
      r_d0 = v;
      r_sem_n = 1'b0;
      r_rw_n = 1'b0;
      tick;
      r_rw_n = 1'b1;
      r_sem_n = 1'b1;
      tick;
   endtask
   task automatic t_try;
      cmd(DPS_OP_TRY, 3'h3);
      chk(g, 1'b1);
      rw(3'h3, 1'b0);
      chk(r_q, 1'b1);
      cmd(DPS_OP_RELEASE, 3'h3);
      chk(r_q, 1'b0);
      rw(3'h3, 1'b1);
   endtask
   task automatic t_boot;
      for (int s = 0; s < 8; s++) begin
         rw(3'(s), 1'b0);
         chk(r_q, 1'b0);
         rw(3'(s), 1'b1);
      end
   endtask
   task automatic t_deny;
      rw(3'h5, 1'b0);
      cmd(DPS_OP_TRY, 3'h5);
      chk(g, 1'b0);
      rw(3'h5, 1'b1);
      rw(3'h5, 1'b0);
      chk(r_q, 1'b0);
      rw(3'h5, 1'b1);
   endtask
   task automatic t_acq;
      rw(3'h6, 1'b0);
      fork
         cmd(DPS_OP_ACQUIRE, 3'h6);
         begin
            repeat (40) tick;
            rw(3'h6, 1'b1);
         end
      join
      chk(g, 1'b1);
      chk(r_q, 1'b1);
      cmd(DPS_OP_RELEASE, 3'h6);
   endtask
   task automatic t_cancel;
      rw(3'h7, 1'b0);
      acquire_cancel = 1'b1;
      cmd(DPS_OP_ACQUIRE, 3'h7);
      acquire_cancel = 1'b0;
      chk(g, 1'b0);
      rw(3'h7, 1'b1);
      rw(3'h7, 1'b0);
      chk(r_q, 1'b0);
      rw(3'h7, 1'b1);
   endtask
   task automatic t_init;
      cmd(DPS_OP_TRY, 3'h2);
      chk(g, 1'b1);
      cmd(DPS_OP_INIT, 3'h0);
      rw(3'h2, 1'b0);
      chk(r_q, 1'b0);
   endtask
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   initial begin
      resetn = 1'b0;
      cmd_valid = 1'b0;
      cmd_op = DPS_OP_INIT;
      cmd_sel = 3'h0;
      acquire_cancel = 1'b0;
      r_sel = 3'h0;
      r_sem_n = 1'b1;
      r_rw_n = 1'b1;
      r_d0 = 1'b1;
      err_count = 0;
      n_checks = 0;
      repeat (5) tick;
      resetn = 1'b1;
      for (int s = 0; s < 8; s++) rw(3'(s), 1'b1);
      t_try;
      t_boot;
      t_deny;
      t_acq;
      t_cancel;
      t_init;
      print_verdict;
   end
endmodule // dps_sem_host_bench
`default_nettype wire
